/* File: rtl/ext_bus_pkg.sv */
// shared constants and types for the external bus drive control block
package ext_bus_pkg;

  // ********************************************************************
  // widths
  // ********************************************************************
  localparam int ADDR_W = 23;
  localparam int SHARED_ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int WAIT_W = 3;

  // ********************************************************************
  // timing and reset values
  // ********************************************************************
  // ready is only looked at when at least this many wait states are set
  localparam logic [WAIT_W-1:0] READY_MIN_WAITS = 3'h2;
  localparam logic [WAIT_W-1:0] WAIT_RESET = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 23'h000000;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

  // ********************************************************************
  // enumerations
  // ********************************************************************
  typedef enum logic [1:0] {
    SPACE_DATA,
    SPACE_PROG,
    SPACE_IO
  } space_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCESS,
    ST_HOLD
  } bus_state_e;

endpackage

/* File: rtl/bus_ctl_if.sv */
// control carrier between the bus sequencer and the two pin drivers
interface bus_ctl_if;
  import ext_bus_pkg::*;

  logic addr_load;
  logic addr_prog;
  logic addr_float;
  logic [ADDR_W-1:0] addr_value;
  logic [ADDR_W-1:0] addr_q;
  logic addr_oe;
  logic addr_keep;

  logic data_drive;
  logic data_capture;
  logic holder_en;
  logic [DATA_W-1:0] data_value;
  logic [DATA_W-1:0] data_q;
  logic data_oe;
  logic data_keep;

  modport seq (
    output addr_load, addr_prog, addr_float, addr_value,
    output data_drive, data_capture, holder_en, data_value,
    input addr_q, addr_oe, addr_keep, data_q, data_oe, data_keep
  );
  modport addr (
    input addr_load, addr_prog, addr_float, addr_value,
    output addr_q, addr_oe, addr_keep
  );
  modport data (
    input data_drive, data_capture, holder_en, data_value,
    output data_q, data_oe, data_keep
  );
endinterface

/* File: rtl/address_drive.sv */
// address pin driver with upper-line gating and bus holder
module address_drive (
  input wire logic clk_in, // core clock
  input wire logic rst_in, // synchronous reset, high
  input wire logic ce_in, // clock enable
  bus_ctl_if.addr ctl // sequencer control
);
  import ext_bus_pkg::*;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic oe;
  } addr_state_s;

  addr_state_s st_reg;
  addr_state_s st_next;

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb begin
    st_next = st_reg;
    if (ctl.addr_load) begin
      // low lines are shared by every space [RULE1]
      st_next.addr[SHARED_ADDR_W-1:0] = ctl.addr_value[SHARED_ADDR_W-1:0];
      // upper lines only move for program space [RULE2]
      if (ctl.addr_prog) begin
        st_next.addr[ADDR_W-1:SHARED_ADDR_W] = ctl.addr_value[ADDR_W-1:SHARED_ADDR_W];
      end
    end
    // whole bus floats in hold or on float control [RULE3] [RULE4]
    st_next.oe = ~ctl.addr_float;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_reg <= '{addr: ADDR_RESET, oe: 1'b1};
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  assign ctl.addr_q = st_reg.addr;
  assign ctl.addr_oe = st_reg.oe;
  // holder on whenever the bus is not driven: the held level is the last value driven, unless an access accepted under float control loads a new address [RULE5]
  assign ctl.addr_keep = ~st_reg.oe;
endmodule

/* File: rtl/data_drive.sv */
// data pin driver with switchable bus holder
module data_drive (
  input wire logic clk_in, // core clock
  input wire logic rst_in, // synchronous reset, high
  input wire logic ce_in, // clock enable
  input wire logic [ext_bus_pkg::DATA_W-1:0] bus_level_in, // synced level of the pins
  bus_ctl_if.data ctl // sequencer control
);
  import ext_bus_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic oe;
  } data_state_s;

  data_state_s st_reg;
  data_state_s st_next;

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb begin
    st_next = st_reg;
    // drive only while write data is out [RULE8]
    st_next.oe = ctl.data_drive;
    if (ctl.data_drive) begin
      st_next.data = ctl.data_value;
    end else if (ctl.data_capture) begin
      // a read leaves the external level on the wire; hold that one [RULE9]
      st_next.data = bus_level_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_reg <= '{data: DATA_RESET, oe: 1'b0};
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  assign ctl.data_q = st_reg.data;
  assign ctl.data_oe = st_reg.oe;
  // holder only while enabled and not driving [RULE9] [RULE10]
  assign ctl.data_keep = ctl.holder_en & ~st_reg.oe;
endmodule

/* File: rtl/external_bus_drive_control.sv */
// external parallel bus sequencer with pin drive, float and holder control
// Operation
// RULE1: 23-bit address, low 16 shared by spaces
// RULE2: upper 7 address lines for program space only
// RULE3: address bus floats during hold
// RULE4: float control low floats address and data
// RULE5: address holder keeps last driven level; an access accepted under float control loads a new, never driven address
// RULE6: 16-bit two-way data bus, bit 15 high
// RULE7: one data bus for all spaces
// RULE8: drive data only for writes; float in reset/hold
// RULE9: data holder keeps previous level when undriven
// RULE10: holder enable input gates data retention
// RULE11: one space select low during its access
// RULE12: direction high for reads, low writes, floats hold
// RULE13: ready sampled after two or more wait states
module external_bus_drive_control #(
  parameter int ADDR_WIDTH = ext_bus_pkg::ADDR_W, // address lines
  parameter int DATA_WIDTH = ext_bus_pkg::DATA_W // data lines
) (
  input wire logic clk_in, // core clock, 40 MHz
  input wire logic rst_in, // synchronous reset, high
  input wire logic ce_in, // clock enable, freezes all state when low
  input wire logic device_reset_in_n, // device reset pin, low active
  input wire logic hold_req_in_n, // bus hold request pin, low active
  input wire logic float_ctrl_in_n, // output float control pin, low floats
  input wire logic ready_in, // external ready pin
  input wire logic holder_enable_in, // data bus holder enable setting
  input wire logic [ext_bus_pkg::WAIT_W-1:0] wait_states_in, // software wait states
  input wire logic req_valid_in, // core access request
  output logic req_ready_out, // request accepted this cycle
  input wire logic req_write_in, // 1 write, 0 read
  input wire ext_bus_pkg::space_e req_space_in, // target space
  input wire logic [ext_bus_pkg::ADDR_W-1:0] req_addr_in, // access address
  input wire logic [ext_bus_pkg::DATA_W-1:0] req_wdata_in, // write data
  output logic done_out, // access finished, one cycle
  output logic [ext_bus_pkg::DATA_W-1:0] rd_data_out, // read data
  output logic hold_ack_out_n, // hold granted, low active
  output logic [ext_bus_pkg::ADDR_W-1:0] ext_address_bus_out, // address level
  output logic ext_address_bus_oe_out, // address driven
  output logic ext_address_bus_keep_out, // address holder active
  input wire logic [ext_bus_pkg::DATA_W-1:0] ext_data_bus_in, // data pin level
  output logic [ext_bus_pkg::DATA_W-1:0] ext_data_bus_out, // data level
  output logic ext_data_bus_oe_out, // data driven
  output logic ext_data_bus_keep_out, // data holder active
  output logic data_space_select_n, // data space select
  output logic program_space_select_n, // program space select
  output logic io_space_select_n, // io space select
  output logic memory_access_strobe_n, // memory strobe
  output logic read_write_out, // 1 read, 0 write
  output logic ctl_oe_out // selects, strobe and direction driven
);
  import ext_bus_pkg::*;

  // ********************************************************************
  // elaboration checks
  // ********************************************************************
  // the pin drivers are sized from the package, so other widths cannot be served
  if (ADDR_WIDTH != ADDR_W) begin : g_addr_width_check
    $error("address width must equal the package address width");
  end
  if (DATA_WIDTH != DATA_W) begin : g_data_width_check
    $error("data width must equal the package data width");
  end
  // the upper program lines need room above the shared lines
  if (SHARED_ADDR_W >= ADDR_WIDTH) begin : g_shared_width_check
    $error("shared address lines must leave upper program lines");
  end

  // ********************************************************************
  // state
  // ********************************************************************
  typedef struct packed {
    // sequencer
    bus_state_e state;
    logic [WAIT_W-1:0] wait_cnt;
    logic [WAIT_W-1:0] wait_prog;
    logic write;
    space_e space;
    logic [DATA_W-1:0] wdata;
    // two-flop pin synchronisers
    logic rst_s1;
    logic rst_s2;
    logic hold_s1;
    logic hold_s2;
    logic float_s1;
    logic float_s2;
    logic ready_s1;
    logic ready_s2;
    logic [DATA_W-1:0] din_s1;
    logic [DATA_W-1:0] din_s2;
    // registered pin controls and core results
    logic ds_n;
    logic ps_n;
    logic is_n;
    logic strb_n;
    logic rw;
    logic ctl_oe;
    logic hold_ack_n;
    logic done;
    logic [DATA_W-1:0] rd_data;
  } seq_state_s;

  seq_state_s st_reg;
  seq_state_s st_next;
  bus_ctl_if ctl ();

  logic dev_rst_n;
  logic hold_n;
  logic float_n;
  logic ready_s;
  logic start;
  logic finish;
  logic access_next;
  logic count_done;
  logic ready_ok;

  // ********************************************************************
  // helpers
  // ********************************************************************
  function automatic logic needs_ready(input logic [WAIT_W-1:0] ws);
    needs_ready = (ws >= READY_MIN_WAITS);
  endfunction

  // active-low select for one space while an access is under way
  function automatic logic space_sel_n(input logic active, input space_e sp, input space_e want);
    space_sel_n = ~(active & (sp == want));
  endfunction

  assign dev_rst_n = st_reg.rst_s2;
  assign hold_n = st_reg.hold_s2;
  assign float_n = st_reg.float_s2;
  assign ready_s = st_reg.ready_s2;
  // a hold request refuses new work so that hold is granted between accesses
  assign req_ready_out = (st_reg.state == ST_IDLE) & dev_rst_n & hold_n;
  assign start = req_valid_in & req_ready_out;
  assign count_done = (st_reg.state == ST_ACCESS) & (st_reg.wait_cnt == WAIT_RESET);
  // with few wait states the count alone ends the access
  assign ready_ok = ~needs_ready(st_reg.wait_prog) | ready_s;
  // ready waits one cycle and is checked again while low [RULE13]
  assign finish = count_done & ready_ok;

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb begin
    st_next = st_reg;
    // pins pass two flops before use
    // level requests only, so a plain flop pair is enough
    st_next.rst_s1 = device_reset_in_n;
    st_next.rst_s2 = st_reg.rst_s1;
    st_next.hold_s1 = hold_req_in_n;
    st_next.hold_s2 = st_reg.hold_s1;
    st_next.float_s1 = float_ctrl_in_n;
    st_next.float_s2 = st_reg.float_s1;
    st_next.ready_s1 = ready_in;
    st_next.ready_s2 = st_reg.ready_s1;
    // data word passes the same two flops, so a read takes the level from two cycles back
    st_next.din_s1 = ext_data_bus_in;
    st_next.din_s2 = st_reg.din_s1;
    st_next.done = 1'b0;

    case (st_reg.state)
      ST_IDLE: begin
        // a pending hold wins over a new request
        if (~hold_n) begin
          st_next.state = ST_HOLD;
        end else if (start) begin
          // every request field is taken on the accept edge
          st_next.state = ST_ACCESS;
          st_next.wait_cnt = wait_states_in;
          st_next.wait_prog = wait_states_in;
          st_next.write = req_write_in;
          st_next.space = req_space_in;
          st_next.wdata = req_wdata_in;
        end
      end
      ST_ACCESS: begin
        if (~dev_rst_n) begin
          // device reset abandons the access
          st_next.state = ST_IDLE;
        end else if (st_reg.wait_cnt != WAIT_RESET) begin
          // software wait states run first, ready is not looked at yet
          st_next.wait_cnt = st_reg.wait_cnt - 3'h1;
        end else if (finish) begin
          st_next.state = ST_IDLE;
          st_next.done = 1'b1;
          // one data bus serves every space [RULE7]
          if (~st_reg.write) begin
            st_next.rd_data = st_reg.din_s2;
          end
        end
      end
      ST_HOLD: begin
        // released once the synced request is high again
        if (hold_n) begin
          st_next.state = ST_IDLE;
        end
      end
      default: begin
        // unused encodings fall back to idle
        st_next.state = ST_IDLE;
      end
    endcase

    access_next = (st_next.state == ST_ACCESS);
    // exactly one select low, only while the access runs [RULE11]
    st_next.ds_n = space_sel_n(access_next, st_next.space, SPACE_DATA);
    st_next.ps_n = space_sel_n(access_next, st_next.space, SPACE_PROG);
    st_next.is_n = space_sel_n(access_next, st_next.space, SPACE_IO);
    // io accesses leave the memory strobe high
    st_next.strb_n = ~(access_next & (st_next.space != SPACE_IO));
    // direction stays high except during a write [RULE12]
    st_next.rw = ~(access_next & st_next.write);
    // control pins float in hold and on float control [RULE12]
    st_next.ctl_oe = (st_next.state != ST_HOLD) & float_n;
    // acknowledge from the same next state as the floats, so pins and ack agree
    st_next.hold_ack_n = (st_next.state != ST_HOLD);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_reg <= '{
        state: ST_IDLE,
        wait_cnt: WAIT_RESET,
        wait_prog: WAIT_RESET,
        write: 1'b0,
        space: SPACE_DATA,
        wdata: DATA_RESET,
        rst_s1: 1'b0,
        rst_s2: 1'b0,
        hold_s1: 1'b1,
        hold_s2: 1'b1,
        float_s1: 1'b1,
        float_s2: 1'b1,
        ready_s1: 1'b0,
        ready_s2: 1'b0,
        din_s1: DATA_RESET,
        din_s2: DATA_RESET,
        ds_n: 1'b1,
        ps_n: 1'b1,
        is_n: 1'b1,
        strb_n: 1'b1,
        rw: 1'b1,
        ctl_oe: 1'b1,
        hold_ack_n: 1'b1,
        done: 1'b0,
        rd_data: DATA_RESET
      };
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  // ********************************************************************
  // pin driver control
  // ********************************************************************
  // each driver owns its pin state; the sequencer only steers it
  // loads use the next-state values so address and selects change together
  assign ctl.addr_load = start;
  assign ctl.addr_prog = (req_space_in == SPACE_PROG);
  assign ctl.addr_value = req_addr_in;
  // hold or float control releases the address bus [RULE3] [RULE4]
  assign ctl.addr_float = (st_next.state == ST_HOLD) | ~float_n;
  // write data only; never in reset, hold request or float [RULE8] [RULE4]
  assign ctl.data_drive = access_next & st_next.write & dev_rst_n & hold_n & float_n;
  assign ctl.data_value = st_next.wdata;
  // the holder keeps what the wire showed at the end of a read
  assign ctl.data_capture = finish & ~st_reg.write;
  assign ctl.holder_en = holder_enable_in; // [RULE10]

  address_drive u_addr (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .ctl(ctl.addr)
  );

  data_drive u_data (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .bus_level_in(st_reg.din_s2),
    .ctl(ctl.data)
  );

  // ********************************************************************
  // outputs
  // ********************************************************************
  // core side
  assign done_out = st_reg.done;
  assign rd_data_out = st_reg.rd_data;
  assign hold_ack_out_n = st_reg.hold_ack_n;
  // pin side
  assign ext_address_bus_out = ctl.addr_q; // [RULE1]
  assign ext_address_bus_oe_out = ctl.addr_oe;
  assign ext_address_bus_keep_out = ctl.addr_keep; // [RULE5]
  assign ext_data_bus_out = ctl.data_q; // [RULE6]
  assign ext_data_bus_oe_out = ctl.data_oe;
  assign ext_data_bus_keep_out = ctl.data_keep; // [RULE9]
  assign data_space_select_n = st_reg.ds_n;
  assign program_space_select_n = st_reg.ps_n;
  assign io_space_select_n = st_reg.is_n;
  assign memory_access_strobe_n = st_reg.strb_n;
  assign read_write_out = st_reg.rw;
  assign ctl_oe_out = st_reg.ctl_oe;
endmodule

/* File: test/ext_bus_props.sv */
// concurrent checks on the pins of the external bus drive control block
module ext_bus_props import ext_bus_pkg::*; (
  input wire logic clk_in, rst_in, device_reset_in_n, float_ctrl_in_n, holder_enable_in, // inputs
  input wire logic req_ready_out, hold_ack_out_n, ext_address_bus_oe_out, ext_address_bus_keep_out, // status
  input wire logic ext_data_bus_oe_out, ext_data_bus_keep_out, read_write_out, ctl_oe_out, // drive
  input wire logic data_space_select_n, program_space_select_n, io_space_select_n, memory_access_strobe_n, // selects
  input wire logic [ADDR_W-1:0] req_addr_in, ext_address_bus_out, // address
  input wire logic [DATA_W-1:0] req_wdata_in, ext_data_bus_out // data
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ****************
  // pin drive checks
  // ****************
  a_data_write_only: assert property (ext_data_bus_oe_out |-> !read_write_out && ctl_oe_out)
    else $error("data bus driven outside a write");
  a_hold_all_float: assert property (!hold_ack_out_n |->
    !ext_address_bus_oe_out && !ext_data_bus_oe_out && !ctl_oe_out) else $error("pins driven in hold");
  a_float_pin_off: assert property (!float_ctrl_in_n [*4] |->
    !ext_address_bus_oe_out && !ext_data_bus_oe_out) else $error("float control ignored");
  a_addr_keep_level: assert property (!ext_address_bus_oe_out |->
    ext_address_bus_keep_out && $stable(ext_address_bus_out)) else $error("address holder lost level");
  a_data_keep_gate: assert property (ext_data_bus_keep_out ==
    (holder_enable_in && !ext_data_bus_oe_out)) else $error("data holder enable wrong");
  a_one_select: assert property (ctl_oe_out |->
    $countones({data_space_select_n, program_space_select_n, io_space_select_n}) >= 2)
    else $error("more than one space select low");
  a_strobe_mem_only: assert property (ctl_oe_out |->
    memory_access_strobe_n == (data_space_select_n && program_space_select_n)) else $error("memory strobe wrong");
  a_shared_addr: assert property ($fell(data_space_select_n) || $fell(io_space_select_n) |->
    ext_address_bus_out == {$past(ext_address_bus_out[22:16]), $past(req_addr_in[15:0])})
    else $error("data or io address wrong");
  a_prog_addr: assert property ($fell(program_space_select_n) |->
    ext_address_bus_out == $past(req_addr_in)) else $error("program address wrong");
  a_write_data: assert property ($rose(ext_data_bus_oe_out) |->
    ext_data_bus_out == $past(req_wdata_in)) else $error("write data wrong");
  a_reset_float: assert property (!device_reset_in_n [*4] |->
    !ext_data_bus_oe_out && !req_ready_out) else $error("data bus driven in device reset");
endmodule

bind external_bus_drive_control ext_bus_props ext_bus_props_inst (
  .clk_in, .rst_in, .device_reset_in_n, .float_ctrl_in_n, .holder_enable_in, .req_ready_out,
  .hold_ack_out_n, .ext_address_bus_oe_out, .ext_address_bus_keep_out, .ext_data_bus_oe_out,
  .ext_data_bus_keep_out, .read_write_out, .ctl_oe_out, .data_space_select_n, .program_space_select_n,
  .io_space_select_n, .memory_access_strobe_n, .req_addr_in, .ext_address_bus_out, .req_wdata_in, .ext_data_bus_out
);

/* File: test/ext_mem_model.sv */
// external memory and io device model with a resolved data wire
module ext_mem_model (
  input wire logic clk_in, // core clock
  input wire logic [3:0] slow_in, // cycles ready stays low per access
  input wire logic [22:0] addr_in, // address pins
  input wire logic [2:0] sel_n_in, // data, program, io selects
  input wire logic rw_in, // 1 read
  input wire logic drv_on_in, // control pins driven
  input wire logic [15:0] dout_in, // design data level
  input wire logic doe_in, // design drives data
  input wire logic keep_in, // design holder active
  output logic [15:0] wire_out, // resolved data wire
  output logic ready_out // ready pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [128];
  logic [15:0] last = 16'h0000;
  logic [3:0] wait_cnt = 4'h0;
  logic sel;
  logic [6:0] idx;
  assign sel = drv_on_in && (sel_n_in != 3'h7);
  assign idx = {sel_n_in[2:1], addr_in[4:0]};
  // a selected device outdrives the weak holder during a read
  always_comb begin
    if (doe_in) wire_out = dout_in;
    else if (sel && rw_in) wire_out = mem[idx];
    else if (keep_in) wire_out = dout_in;
    else wire_out = ~last; // no pull: a released wire must not show a stale value
  end
  always_ff @(posedge clk_in) begin
    last <= wire_out;
    if (sel && !rw_in && doe_in) mem[idx] <= dout_in;
    wait_cnt <= !sel ? slow_in : (wait_cnt == 4'h0 ? 4'h0 : wait_cnt - 4'h1);
  end
  assign ready_out = (wait_cnt == 4'h0);
endmodule

/* File: test/tb.sv */
// self-checking bench for the external bus drive control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ext_bus_pkg::*;
  logic clk_in = 1'b0, rst_in = 1'b1, dev_n = 1'b1, hold_n = 1'b1, float_n = 1'b1, holder_en = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0;
  logic [2:0] ws = 3'h0;
  logic [3:0] slow = 4'h0;
  space_e sp = SPACE_DATA;
  logic [ADDR_W-1:0] addr = 23'h000000, aout;
  logic [DATA_W-1:0] wdata = 16'h0000, rdata, dout, dbus;
  logic req_ready, done, hold_ack_n, aoe, doe, dkeep, ctl_oe, ready, dsn, psn, isn, rw;
  int n_fail = 0, num_checks = 0, cycles = 0;
  external_bus_drive_control external_bus_drive_control_inst (
    .clk_in, .rst_in, .ce_in(1'b1), .device_reset_in_n(dev_n), .hold_req_in_n(hold_n),
    .float_ctrl_in_n(float_n), .ready_in(ready), .holder_enable_in(holder_en), .wait_states_in(ws),
    .req_valid_in(req_valid), .req_ready_out(req_ready), .req_write_in(req_write), .req_space_in(sp),
    .req_addr_in(addr), .req_wdata_in(wdata), .done_out(done), .rd_data_out(rdata),
    .hold_ack_out_n(hold_ack_n), .ext_address_bus_out(aout), .ext_address_bus_oe_out(aoe),
    .ext_address_bus_keep_out(), .ext_data_bus_in(dbus), .ext_data_bus_out(dout),
    .ext_data_bus_oe_out(doe), .ext_data_bus_keep_out(dkeep), .data_space_select_n(dsn),
    .program_space_select_n(psn), .io_space_select_n(isn), .memory_access_strobe_n(),
    .read_write_out(rw), .ctl_oe_out(ctl_oe)
  );
  ext_mem_model ext_mem_model_inst (
    .clk_in, .slow_in(slow), .addr_in(aout), .sel_n_in({dsn, psn, isn}), .rw_in(rw), .drv_on_in(ctl_oe),
    .dout_in(dout), .doe_in(doe), .keep_in(dkeep), .wire_out(dbus), .ready_out(ready)
  );
  // ****************
  // clock and helpers
  // ****************
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // cyc counts negedges from the take edge to the one after done; 40 means no done
  task automatic acc(input logic w, input space_e s, input logic [22:0] a, input logic [15:0] d,
                     input logic [2:0] k, output int cyc);
    int n;
    @(posedge clk_in);
    req_valid <= 1'b1;
    req_write <= w;
    sp <= s;
    addr <= a;
    wdata <= d;
    ws <= k;
    @(negedge clk_in);
    for (n = 0; n < 40 && req_ready !== 1'b1; n++) @(negedge clk_in);
    @(posedge clk_in);
    req_valid <= 1'b0;
    @(negedge clk_in);
    for (cyc = 1; cyc < 40 && done !== 1'b1; cyc++) @(negedge clk_in);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_spaces();
    int cyc;
    logic [6:0] up;
    up = 7'h00;
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, space_e'(i), {7'h2a + 7'(i), 16'h0010 + 16'(i)}, 16'hc0de ^ 16'(i * 9), 3'h0, cyc);
      if (i == 1) up = 7'h2b;
      check(aout, {up, 16'h0010 + 16'(i)});
    end
    for (int i = 0; i < 3; i++) begin
      acc(1'b0, space_e'(i), {7'h00, 16'h0010 + 16'(i)}, 16'h0000, 3'h2, cyc);
      check(rdata, 16'hc0de ^ 16'(i * 9));
      check(cyc, 4);
    end
  endtask
  task automatic t_waits();
    int cyc;
    logic [3:0] sl [3] = '{4'h6, 4'h6, 4'h0};
    int ex [3] = '{3, 0, 5};
    for (int i = 0; i < 3; i++) begin
      slow <= sl[i];
      acc(1'b0, SPACE_DATA, 23'h000010, 16'h0000, 3'(i + 1), cyc);
      if (i == 1) check(cyc > 4, 1);
      else check(cyc, ex[i]);
      if (i > 0) check(rdata, 16'hc0de);
    end
    slow <= 4'h0;
  endtask
  task automatic t_holder();
    int cyc;
    logic [15:0] w1;
    acc(1'b1, SPACE_IO, 23'h000005, 16'h5a0f, 3'h0, cyc);
    repeat (2) @(negedge clk_in);
    check(dbus, 16'h5a0f);
    @(posedge clk_in);
    holder_en <= 1'b0;
    @(negedge clk_in);
    w1 = dbus;
    @(negedge clk_in);
    check(dkeep, 1'b0);
    check(dbus == w1, 1'b0);
    @(posedge clk_in);
    holder_en <= 1'b1;
  endtask
  // a pin goes low at the take edge while a long write runs
  task automatic t_pin_mid(input logic dev);
    int cyc;
    fork
      acc(1'b1, SPACE_DATA, 23'h000011, 16'h1234, 3'h7, cyc);
      begin
        repeat (2) @(posedge clk_in);
        if (dev) dev_n <= 1'b0;
        else float_n <= 1'b0;
        @(negedge clk_in);
        check(doe, 1'b1);
        repeat (4) @(negedge clk_in);
        if (dev) check({doe, req_ready}, 2'b00);
        else check({aoe, doe}, 2'b00);
        @(posedge clk_in);
        dev_n <= 1'b1;
        float_n <= 1'b1;
      end
    join
    check(cyc, dev ? 40 : 9);
  endtask
  task automatic t_hold();
    int cyc;
    int n;
    fork
      acc(1'b0, SPACE_PROG, 23'h4d0011, 16'h0000, 3'h4, cyc);
      begin
        repeat (2) @(posedge clk_in);
        hold_n <= 1'b0;
      end
    join
    check({cyc[7:0], rdata}, {8'd6, 16'hc0d7});
    for (n = 0; n < 20 && hold_ack_n !== 1'b0; n++) @(negedge clk_in);
    check({aoe, doe, ctl_oe, req_ready}, 4'h0);
    check(aout, 23'h4d0011);
    @(posedge clk_in);
    hold_n <= 1'b1;
    repeat (4) @(negedge clk_in);
    check({hold_ack_n, aoe}, 2'b11);
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    t_spaces();
    t_waits();
    t_holder();
    t_pin_mid(1'b0);
    t_pin_mid(1'b1);
    t_hold();
    finish_test();
  end
endmodule
